// *** design/xbi_defines.svh ***
// Timing counts, reset values and region bounds of the expansion bus block
`ifndef XBI_DEFINES_SVH
`define XBI_DEFINES_SVH
`define XBI_CLK_PERIOD_NS 20
`define XBI_SYNC_CYC 3
`define XBI_CS1_WAIT_RST 2'h3
`define XBI_CS0_WAIT_RST 3'h3
`define XBI_CS0_LOW_NARROW 16'h1000
`define XBI_SPLIT_HIGH 16'h8000
`define XBI_SPLIT_LOW 16'h4000
`define XBI_PIN_OFF 2'h0
`define XBI_PIN_PH4_CS0 2'h1
`endif

// *** design/xbi_pkg.sv ***
// Types shared by the expansion bus block
package xbi_pkg;
  typedef enum logic [2:0] {XBI_IDLE, XBI_ADDR, XBI_PH4, XBI_WAIT, XBI_DATA} xbi_state_t;
  typedef logic [15:0] xbi_addr_t;
  typedef logic [7:0] xbi_data_t;
endpackage

// *** design/xbi_wait_gen.sv ***
// Wait-state counter that holds the stall for a loaded number of cycles
`timescale 1ns/1ns
module xbi_wait_gen
  import xbi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [2:0] count,
  output logic stall,
  output logic finish
);
  logic [2:0] left_r;
  logic [2:0] left_nxt;
  logic run_r;
  logic run_nxt;

  // Counts bus clocks; a zero load finishes at once with no stall
  always_comb
  begin
    left_nxt = left_r;
    run_nxt = run_r;
    if (load)
    begin
      left_nxt = count;
      run_nxt = (count != 3'h0);
    end
    else if (run_r)
    begin
      left_nxt = left_r - 3'h1;
      run_nxt = (left_r != 3'h1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left_r <= 3'h0;
      run_r <= 1'b0;
    end
    else
    begin
      left_r <= left_nxt;
      run_r <= run_nxt;
    end
  end

  assign stall = run_r;
  assign finish = (load && count == 3'h0) || (run_r && left_r == 3'h1);
endmodule

// *** design/xbi_core.sv ***
// Expansion bus block: carries processor bus cycles out to external devices
// Functional notes
// - Sixteen address, eight data, two selects, three controls
// - External space covers 64K from sixteen bits
// - Program select: zero to three wait states
// - General select: up to seven wait states
// - Low noise drives lines only on externals or visibility
// - Low noise address holds between external accesses and internal ones shown by visibility
// - High performance drives lines without gating
// - Select regions picked from four combinations
// - Each select: enable, polarity, wait count
// - Read passes external data inward
// - Write passes internal data outward
// - Visibility copies internal cycles onto data
// - Strobes derived from read/write line
// - External qualifier quiets outputs on internals
// - Build option disables the whole interface
// - Wait output drives processor stall request
// - Stall length from software or hardware
// - Never stall during internal cycles
// - Select asserted when address in region
// - Timing pin lets external logic pick waits
// - External count on data two-to-zero at phase four
// - Two-bit setting controls timing pin
// - Reset configures maximum program wait count, general wait three
// - Strobes only on externals or visibility
`timescale 1ns/1ns
`include "xbi_defines.svh"
module xbi_core
#(
  parameter bit EXT_BUS_ENABLE_OPTION = 1'b1
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic access_valid,
  input wire xbi_pkg::xbi_addr_t internal_address_bus,
  input wire xbi_pkg::xbi_data_t internal_data_bus_in,
  output xbi_pkg::xbi_data_t internal_data_bus_out,
  output logic internal_data_bus_oe,
  input wire logic internal_read_write,
  input wire logic internal_hit,
  output logic processor_stall_request,
  output logic access_done,
  output logic busy,
  input wire logic cfg_write,
  input wire logic low_noise_mode,
  input wire logic internal_visibility_bit,
  input wire logic [1:0] cs_region_sel,
  input wire logic cs0_enable,
  input wire logic cs0_polarity,
  input wire logic [2:0] cs0_wait,
  input wire logic cs0_ext_wait_mode,
  input wire logic cs1_enable,
  input wire logic cs1_polarity,
  input wire logic [1:0] cs1_wait,
  input wire logic [1:0] wait_pin_mode,
  output xbi_pkg::xbi_addr_t ext_address,
  output logic ext_address_oe,
  input wire xbi_pkg::xbi_data_t ext_data_in,
  output xbi_pkg::xbi_data_t ext_data_out,
  output logic ext_data_oe,
  output logic chip_select_general,
  output logic chip_select_program,
  output logic external_read_strobe_n,
  output logic external_write_strobe_n,
  output logic wait_select_timing_pin,
  output logic wait_select_timing_pin_oe
);
  import xbi_pkg::*;

  // Region decode: program select always owns the top, general select sits below it
  function automatic logic [1:0] region_hit(input xbi_addr_t a, input logic [1:0] sel);
    xbi_addr_t split;
    xbi_addr_t low;
    split = sel[0] ? `XBI_SPLIT_LOW : `XBI_SPLIT_HIGH;
    low = sel[1] ? 16'h0000 : `XBI_CS0_LOW_NARROW;
    region_hit = {a >= split, (a < split) && (a >= low)};
  endfunction

  // Reset synchroniser; release is clocked, assertion is immediate
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // Each data pin passes three stages; a bit counts once its last two stages agree.
  // Per-bit, so one pin that keeps moving cannot hold the others back.
  xbi_data_t din_s1_r;
  xbi_data_t din_s2_r;
  xbi_data_t din_s3_r;
  xbi_data_t din_ok_r;
  xbi_data_t din_ok_nxt;
  always_comb
  begin
    din_ok_nxt = (din_s3_r & ~(din_s2_r ^ din_s3_r)) | (din_ok_r & (din_s2_r ^ din_s3_r));
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
      din_s3_r <= 8'h00;
      din_ok_r <= 8'h00;
    end
    else
    begin
      din_s1_r <= ext_data_in;
      din_s2_r <= din_s1_r;
      din_s3_r <= din_s2_r;
      din_ok_r <= din_ok_nxt;
    end
  end

  // Software settings, captured on cfg_write; program wait resets to its maximum, general wait to three
  logic lown_r, vis_r, cs0_en_r, cs0_pol_r, cs0_ext_r, cs1_en_r, cs1_pol_r;
  logic [1:0] region_r, pin_mode_r, cs1_wait_r;
  logic [2:0] cs0_wait_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lown_r <= 1'b1;
      vis_r <= 1'b0;
      region_r <= 2'h0;
      cs0_en_r <= 1'b0;
      cs0_pol_r <= 1'b0;
      cs0_ext_r <= 1'b0;
      cs0_wait_r <= `XBI_CS0_WAIT_RST;
      cs1_en_r <= 1'b0;
      cs1_pol_r <= 1'b0;
      cs1_wait_r <= `XBI_CS1_WAIT_RST;
      pin_mode_r <= `XBI_PIN_OFF;
    end
    else if (cfg_write)
    begin
      lown_r <= low_noise_mode;
      vis_r <= internal_visibility_bit;
      region_r <= cs_region_sel;
      cs0_en_r <= cs0_enable;
      cs0_pol_r <= cs0_polarity;
      cs0_ext_r <= cs0_ext_wait_mode;
      cs0_wait_r <= cs0_wait;
      cs1_en_r <= cs1_enable;
      cs1_pol_r <= cs1_polarity;
      cs1_wait_r <= cs1_wait;
      pin_mode_r <= wait_pin_mode;
    end
  end

  // Access sequencer state
  xbi_state_t state_r, state_nxt;
  logic [1:0] phase_cnt_r, phase_cnt_nxt;
  xbi_addr_t addr_r, addr_nxt;
  xbi_data_t wdata_r, wdata_nxt, rdata_r, rdata_nxt, dout_r, dout_nxt;
  logic rw_r, rw_nxt, ext_r, ext_nxt, hit0_r, hit0_nxt, hit1_r, hit1_nxt;
  logic aoe_r, aoe_nxt, doe_r, doe_nxt, rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt;
  logic cs0_r, cs0_nxt, cs1_r, cs1_nxt, pin_r, pin_nxt, pin_oe_r, pin_oe_nxt;
  logic done_r, done_nxt, idoe_r, idoe_nxt, busy_r, busy_nxt;
  xbi_addr_t addr_out_r, addr_out_nxt;
  logic wait_load;
  logic [2:0] wait_count;
  logic wait_stall;
  logic wait_finish;
  logic [1:0] hits;
  logic take;
  logic ext_take;

  assign hits = region_hit(internal_address_bus, region_r);
  assign take = EXT_BUS_ENABLE_OPTION && state_r == XBI_IDLE && access_valid;
  assign ext_take = !internal_hit;

  // Stall length: program select from software, general select by choice
  always_comb
  begin
    wait_load = 1'b0;
    wait_count = 3'h0;
    if (state_r == XBI_PH4 && phase_cnt_r == 2'h0)
    begin
      wait_load = 1'b1;
      if (!ext_r)
        wait_count = 3'h0;
      else if (hit0_r && cs0_ext_r)
        wait_count = din_ok_r[2:0];
      else if (hit0_r)
        wait_count = cs0_wait_r;
      else if (hit1_r)
        wait_count = {1'b0, cs1_wait_r};
    end
  end

  xbi_wait_gen u_wait (
    .clk(clk),
    .rst_n(rst_n),
    .load(wait_load),
    .count(wait_count),
    .stall(wait_stall),
    .finish(wait_finish)
  );

  // Next values of the sequencer and of its done, busy and read-data outputs
  always_comb
  begin
    state_nxt = state_r;
    phase_cnt_nxt = phase_cnt_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    rw_nxt = rw_r;
    ext_nxt = ext_r;
    hit0_nxt = hit0_r;
    hit1_nxt = hit1_r;
    done_nxt = 1'b0;
    idoe_nxt = 1'b0;
    case (state_r)
      XBI_IDLE:
      begin
        if (take)
        begin
          addr_nxt = internal_address_bus;
          wdata_nxt = internal_data_bus_in;
          rw_nxt = internal_read_write;
          ext_nxt = ext_take;
          hit0_nxt = ext_take && cs0_en_r && hits[0];
          hit1_nxt = ext_take && cs1_en_r && hits[1];
          state_nxt = XBI_ADDR;
        end
      end
      XBI_ADDR:
      begin
        phase_cnt_nxt = 2'h0;
        state_nxt = XBI_PH4;
      end
      XBI_PH4:
      begin
        // Phase four lasts one cycle; the count is taken from the synchronised data at once
        if (phase_cnt_r == 2'h0)
          state_nxt = wait_finish ? XBI_DATA : XBI_WAIT;
        phase_cnt_nxt = 2'h0;
      end
      XBI_WAIT:
      begin
        if (wait_finish)
          state_nxt = XBI_DATA;
      end
      XBI_DATA:
      begin
        if (phase_cnt_r == 2'(`XBI_SYNC_CYC - 1))
        begin
          rdata_nxt = din_ok_r;
          idoe_nxt = rw_r && ext_r;
          done_nxt = 1'b1;
          state_nxt = XBI_IDLE;
        end
        phase_cnt_nxt = phase_cnt_r + 2'h1;
      end
      default:
        state_nxt = XBI_IDLE;
    endcase
    busy_nxt = state_nxt != XBI_IDLE;
  end

  // Pin values follow the state; high performance leaves lines ungated
  always_comb
  begin
    logic act;
    // In low noise, internal cycles only reach the pins while visibility is set
    act = state_nxt != XBI_IDLE && (ext_nxt || vis_r);
    aoe_nxt = lown_r ? act : EXT_BUS_ENABLE_OPTION;
    doe_nxt = 1'b0;
    dout_nxt = dout_r;
    // Low noise address holds its last driven value, from an external cycle or an internal cycle with visibility set
    addr_out_nxt = (lown_r && !act) ? addr_out_r : (act ? addr_nxt : internal_address_bus);
    if (act && !rw_nxt && state_nxt != XBI_PH4)
    begin
      doe_nxt = 1'b1;
      dout_nxt = wdata_nxt;
    end
    else if (!lown_r && EXT_BUS_ENABLE_OPTION && !internal_read_write && state_nxt != XBI_PH4)
    begin
      doe_nxt = 1'b1;
      dout_nxt = internal_data_bus_in;
    end
    rd_n_nxt = !(act && rw_nxt);
    wr_n_nxt = !(act && !rw_nxt);
    cs0_nxt = (act && hit0_nxt) ~^ cs0_pol_r;
    cs1_nxt = (act && hit1_nxt) ~^ cs1_pol_r;
    // Timing pin is active low; its select term ignores the polarity setting
    pin_oe_nxt = EXT_BUS_ENABLE_OPTION && pin_mode_r != `XBI_PIN_OFF;
    if (pin_mode_r == `XBI_PIN_PH4_CS0)
      pin_nxt = !(state_nxt == XBI_PH4 && ext_nxt && hit0_nxt);
    else
      pin_nxt = !(state_nxt == XBI_PH4 && ext_nxt);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= XBI_IDLE;
      phase_cnt_r <= 2'h0;
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
      rdata_r <= 8'h00;
      rw_r <= 1'b1;
      ext_r <= 1'b0;
      hit0_r <= 1'b0;
      hit1_r <= 1'b0;
      done_r <= 1'b0;
      idoe_r <= 1'b0;
      busy_r <= 1'b0;
      addr_out_r <= 16'h0000;
      aoe_r <= 1'b0;
      doe_r <= 1'b0;
      dout_r <= 8'h00;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      cs0_r <= 1'b1;
      cs1_r <= 1'b1;
      pin_r <= 1'b1;
      pin_oe_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      phase_cnt_r <= phase_cnt_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      rw_r <= rw_nxt;
      ext_r <= ext_nxt;
      hit0_r <= hit0_nxt;
      hit1_r <= hit1_nxt;
      done_r <= done_nxt;
      idoe_r <= idoe_nxt;
      busy_r <= busy_nxt;
      addr_out_r <= addr_out_nxt;
      aoe_r <= aoe_nxt;
      doe_r <= doe_nxt;
      dout_r <= dout_nxt;
      rd_n_r <= rd_n_nxt;
      wr_n_r <= wr_n_nxt;
      cs0_r <= cs0_nxt;
      cs1_r <= cs1_nxt;
      pin_r <= pin_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  // Stall flop mirrors the counter so the port comes from a register
  logic stall_r;
  logic stall_nxt;
  always_comb
  begin
    stall_nxt = ext_r && (wait_load ? (wait_count != 3'h0) : (wait_stall && !wait_finish));
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stall_r <= 1'b0;
    else
      stall_r <= stall_nxt;
  end

  // Pin-facing outputs, all registered
  assign ext_address = addr_out_r;
  assign ext_address_oe = aoe_r;
  assign ext_data_out = dout_r;
  assign ext_data_oe = doe_r;
  assign chip_select_general = cs0_r;
  assign chip_select_program = cs1_r;
  assign external_read_strobe_n = rd_n_r;
  assign external_write_strobe_n = wr_n_r;
  assign wait_select_timing_pin = pin_r;
  assign wait_select_timing_pin_oe = pin_oe_r;
  assign processor_stall_request = stall_r;
  assign internal_data_bus_out = rdata_r;
  assign internal_data_bus_oe = idoe_r;
  assign access_done = done_r;
  assign busy = busy_r;
endmodule

// *** verif/xbi_core_sva.sv ***
// Port-level checks of the expansion bus block
`timescale 1ns/1ns
module xbi_core_sva
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic access_valid,
  input wire logic busy,
  input wire logic internal_hit,
  input wire logic processor_stall_request,
  input wire logic access_done,
  input wire logic internal_data_bus_oe,
  input wire logic external_read_strobe_n,
  input wire logic external_write_strobe_n,
  input wire xbi_pkg::xbi_addr_t ext_address,
  input wire logic ext_address_oe
);
  import xbi_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Internal cycles: fixed length, no stall
  done_int_a: assert property (access_valid && !busy && internal_hit |-> ##6 access_done)
    else $error("internal access length wrong");
  stall_int_a: assert property (access_valid && !busy && internal_hit |=>
    !processor_stall_request [*5]) else $error("stall on internal access");
  // Wait states bounded, data phase follows the stall
  stall_max_a: assert property ($rose(processor_stall_request) |->
    ##[1:7] !processor_stall_request) else $error("stall longer than seven");
  stall_end_a: assert property ($fell(processor_stall_request) |-> ##3 access_done)
    else $error("access not done after stall");
  done_win_a: assert property (access_valid && !busy |-> ##[6:13] access_done)
    else $error("access never completed");
  stall_ext_a: assert property (processor_stall_request |->
    !external_read_strobe_n || !external_write_strobe_n) else $error("stall outside access");
  // Strobes exclusive, read data handed in only at completion
  strobe_excl_a: assert property (!external_read_strobe_n |-> external_write_strobe_n)
    else $error("both strobes active");
  rd_oe_a: assert property (internal_data_bus_oe |-> access_done)
    else $error("read data outside done");
  // Undriven address must keep its last value
  addr_hold_a: assert property (!ext_address_oe && !$past(ext_address_oe) |->
    $stable(ext_address)) else $error("address moved while idle");
endmodule

bind xbi_core xbi_core_sva u_sva (.clk(clk), .nrst(nrst), .access_valid(access_valid),
  .busy(busy), .internal_hit(internal_hit), .processor_stall_request(processor_stall_request),
  .access_done(access_done), .internal_data_bus_oe(internal_data_bus_oe),
  .external_read_strobe_n(external_read_strobe_n),
  .external_write_strobe_n(external_write_strobe_n), .ext_address(ext_address),
  .ext_address_oe(ext_address_oe));

// *** verif/xbi_ext_dev.sv ***
// Behavioural external memory with a wait-count driver
`timescale 1ns/1ns
module xbi_ext_dev
(
  input wire logic clk,
  input wire xbi_pkg::xbi_addr_t addr,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire xbi_pkg::xbi_data_t d_out,
  input wire logic d_oe,
  input wire logic [2:0] wcnt,
  output xbi_pkg::xbi_data_t d_drv
);
  import xbi_pkg::*;
  xbi_data_t mem [256];
  logic [4:0] pat_r = 5'h00;
  // Store write data while the strobe is low
  always_ff @(posedge clk)
  begin
    pat_r <= pat_r + 5'h01;
    if (!wr_n && d_oe)
      mem[addr[7:0]] <= d_out;
  end
  // Idle bus shows a moving pattern, so stale data never looks valid
  assign d_drv = !rd_n ? mem[addr[7:0]] : {pat_r, wcnt};
endmodule

// *** verif/xbi_core_bench.sv ***
// Self-checking bench of the expansion bus block
`timescale 1ns/1ns
module xbi_core_bench;
  import xbi_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, av = 1'b0, rw = 1'b1, hit = 1'b0, cw = 1'b0;
  logic lnm = 1'b1, vis = 1'b0, c0p = 1'b0, c0x = 1'b0, c1p = 1'b0, c0e = 1'b1, c1e = 1'b1;
  logic [1:0] rsel = 2'h0, c1w = 2'h3, pm = 2'h0;
  logic [2:0] c0w = 3'h3, wcnt = 3'h0;
  xbi_addr_t ia = 16'h0000, xa, ad;
  xbi_data_t id = 8'h00, idout, xdo, dd, xdi, dt;
  logic idoe, stall, done, busy, xaoe, xdoe, cs0, cs1, rdn, wrn, pin, pinoe;
  int n_errors = 0, checked = 0;
  // Data pins resolve between block and device
  assign xdi = xdoe ? xdo : dd;
  always #10 clk = ~clk;
  xbi_core u_dut (.clk(clk), .nrst(nrst), .access_valid(av), .internal_address_bus(ia),
    .internal_data_bus_in(id), .internal_data_bus_out(idout), .internal_data_bus_oe(idoe),
    .internal_read_write(rw), .internal_hit(hit), .processor_stall_request(stall),
    .access_done(done), .busy(busy), .cfg_write(cw), .low_noise_mode(lnm),
    .internal_visibility_bit(vis), .cs_region_sel(rsel), .cs0_enable(c0e),
    .cs0_polarity(c0p), .cs0_wait(c0w), .cs0_ext_wait_mode(c0x), .cs1_enable(c1e),
    .cs1_polarity(c1p), .cs1_wait(c1w), .wait_pin_mode(pm), .ext_address(xa),
    .ext_address_oe(xaoe), .ext_data_in(xdi), .ext_data_out(xdo), .ext_data_oe(xdoe),
    .chip_select_general(cs0), .chip_select_program(cs1), .external_read_strobe_n(rdn),
    .external_write_strobe_n(wrn), .wait_select_timing_pin(pin),
    .wait_select_timing_pin_oe(pinoe));
  xbi_ext_dev u_dev (.clk(clk), .addr(xa), .rd_n(rdn), .wr_n(wrn), .d_out(xdo), .d_oe(xdoe),
    .wcnt(wcnt), .d_drv(dd));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Config is only captured on the write pulse
  task automatic cfg();
    @(posedge clk);
    cw <= 1'b1;
    @(posedge clk);
    cw <= 1'b0;
  endtask

  // Expected selects: {program, general}; internal always wins
  function automatic logic [1:0] exp_sel(input xbi_addr_t a, input logic h);
    xbi_addr_t sp, lo;
    sp = rsel[0] ? 16'h4000 : 16'h8000;
    lo = rsel[1] ? 16'h0000 : 16'h1000;
    return h ? 2'h0 : {a >= sp, a >= lo && a < sp} & {c1e, c0e};
  endfunction

  // Random and boundary addresses of both regions
  function automatic xbi_addr_t pick(input int j);
    xbi_addr_t sp, lo;
    sp = rsel[0] ? 16'h4000 : 16'h8000;
    lo = rsel[1] ? 16'h0000 : 16'h1000;
    case (j)
      0: return lo + 16'($urandom % (sp - lo));
      1: return sp + 16'($urandom % (17'h10000 - sp));
      2: return sp - 16'h0001;
      3: return sp;
      4: return lo;
      default: return 16'hffff;
    endcase
  endfunction

  // One access, watched cycle by cycle until done
  task automatic acc(input xbi_addr_t a, input logic r, input logic h, input xbi_data_t d);
    logic [1:0] s, es;
    logic rs, ws, pl, ao;
    xbi_data_t dq, rq;
    xbi_addr_t aq;
    int n, ns, en;
    es = exp_sel(a, h);
    en = es[1] ? int'(c1w) : es[0] ? int'(c0x ? wcnt : c0w) : 0;
    s = 2'h0;
    {rs, ws, pl, ao} = 4'h0;
    n = 0;
    ns = 0;
    @(posedge clk);
    av <= 1'b1;
    ia <= a;
    rw <= r;
    hit <= h;
    id <= d;
    @(posedge clk);
    av <= 1'b0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
      ns += int'(stall === 1'b1);
      s |= {cs1 === c1p, cs0 === c0p};
      rs |= (rdn === 1'b0);
      ws |= (wrn === 1'b0);
      pl |= (pinoe === 1'b1 && pin === 1'b0);
      ao |= (xaoe === 1'b1);
      if (xdoe === 1'b1 && wrn === 1'b0)
        dq = xdo;
      if (idoe === 1'b1)
        rq = idout;
      if (xaoe === 1'b1 && (rdn === 1'b0 || wrn === 1'b0))
        aq = xa;
    end
    while (done !== 1'b1 && n < 20);
    chk(16'(n), 16'(en + 5));
    chk(16'(ns), 16'(en));
    chk(16'(s), 16'(es));
    chk(16'({rs, ws}), (h && !vis) ? 16'h0 : 16'({r, !r}));
    chk(16'(pl), 16'(!h && (pm == 2'h1 ? es[0] : pm != 2'h0)));
    if (lnm && !(h && vis))
      chk(16'(ao), 16'(!h));
    else if (!lnm)
      chk(16'(ao), 16'h0001);
    if (!(h && !vis))
      chk(aq, a);
    if (!r && !(h && !vis))
      chk(16'(dq), 16'(d));
    if (r && !h)
      chk(16'(rq), 16'(d));
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(66));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({busy, done, stall, xaoe, xdoe, idoe, pinoe, rdn, wrn, cs0, cs1}, 16'h000f);
    // Every region choice with random waits, polarity, mode and pin use
    for (int r = 0; r < 8; r++)
    begin
      rsel <= r[1:0];
      {lnm, c0p, c1p, c0w, c1w, pm, c0e, c1e} <= 12'($urandom);
      cfg();
      for (int j = 0; j < 6; j++)
      begin
        ad = pick(j);
        dt = 8'($urandom);
        acc(ad, 1'b0, 1'b0, dt);
        acc(ad, 1'b1, 1'b0, dt);
      end
    end
    // Externally supplied wait counts, every value
    // Low noise keeps the block off the data pins, so only the count sits there
    c0x <= 1'b1;
    rsel <= 2'h0;
    lnm <= 1'b1;
    c0e <= 1'b1;
    c1e <= 1'b1;
    for (int w = 0; w < 8; w++)
    begin
      wcnt <= w[2:0];
      pm <= w[1:0];
      cfg();
      acc(16'h2000, 1'b0, 1'b0, {5'h0b, wcnt});
      acc(16'h9000, 1'b0, 1'b0, 8'h3c);
    end
    // Internal cycles with and without visibility
    c0x <= 1'b0;
    for (int v = 0; v < 2; v++)
    begin
      vis <= v[0];
      cfg();
      acc(16'h0040, 1'b0, 1'b1, 8'ha5);
      acc(16'h5000, 1'b1, 1'b1, 8'h00);
    end
    results();
  end

  // Cuts a hang short
  initial
  begin
    #400000;
    n_errors++;
    results();
  end
endmodule
